// ===== logic/smd_ctrl.sv
// control-unit end: software register port drives the cable
// assumes drive answers arrive asynchronously
`timescale 1ns/1ns
module smd_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  smd_if.ctrl cab,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);
  import smd_pkg::*;
  // ----------------------------------------
  // cable drivers and tag sequencer
  // ----------------------------------------
  logic sel_en_reg, if_en_reg;
  logic [sel_w-1:0] sel_num_reg;
  logic [tag_w-1:0] tag_reg;
  logic [bus_w-1:0] bus_reg;
  logic [cnt_w-1:0] cnt_reg;
  cmd_t cmd_reg;
  typedef enum logic [1:0] {idle, setup, hold} step_t;
  step_t step_reg;
  logic busy;
  assign busy = step_reg != idle;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_en_reg <= 1'b0;
      if_en_reg <= 1'b0;
      sel_num_reg <= '0;
      bus_reg <= '0;
    end else if (ce && wr) begin
      if (addr == adr_sel) begin
        sel_num_reg <= wdata[sel_w-1:0];
        sel_en_reg <= wdata[sel_w];
        if_en_reg <= wdata[sel_w+1];
      end else if (addr == adr_bus && !busy) begin
        bus_reg <= wdata[bus_w-1:0];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      step_reg <= idle;
      tag_reg <= '0;
      cnt_reg <= '0;
      cmd_reg <= cmd_none;
    end else if (ce) begin
      case (step_reg)
        idle: begin
          if (wr && addr == adr_cmd && wdata[1:0] != 2'h0) begin
            cmd_reg <= cmd_t'(wdata[1:0]);
            cnt_reg <= cnt_w'(tag_setup_cyc - 1);
            step_reg <= setup;
          end
        end
        setup: begin
          if (cnt_reg == '0) begin
            // one tag only
            tag_reg <= (cmd_reg == cmd_cyl) ? tag_w'(1 << tag_cyl) :
                       (cmd_reg == cmd_head) ? tag_w'(1 << tag_head) : tag_w'(1 << tag_ctl);
            cnt_reg <= cnt_w'(tag_hold_cyc - 1);
            step_reg <= hold;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        hold: begin
          if (cnt_reg == '0) begin
            // control select stays until software issues another command
            if (cmd_reg != cmd_ctl) begin
              tag_reg <= '0;
            end
            step_reg <= idle;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
          if (cnt_reg == '0 && cmd_reg == cmd_ctl) begin
            cmd_reg <= cmd_none;
          end
        end
        default: step_reg <= idle;
      endcase
      if (step_reg == idle && wr && addr == adr_cmd) begin
        tag_reg <= '0;
      end
    end
  end
  // software must only pair write gate with mark enable
  assign cab.sel_en = sel_en_reg;
  assign cab.sel_num = sel_num_reg;
  assign cab.if_en = if_en_reg;
  assign cab.tag = tag_reg;
  assign cab.bus = bus_reg;
  // ----------------------------------------
  // answer synchronisers and read port
  // ----------------------------------------
  localparam int in_w = 1 + st_w;
  logic [in_w-1:0] s1_reg, s2_reg, s3_reg, stable_reg;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      stable_reg <= '0;
    end else if (ce) begin
      s1_reg <= {cab.selected, cab.status};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < in_w; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          stable_reg[i] <= s3_reg[i];
        end
      end
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata <= word_zero;
    end else if (ce) begin
      rdata <= word_zero;
      if (rd) begin
        if (addr == adr_sel) begin
          rdata <= {26'h0, if_en_reg, sel_en_reg, sel_num_reg};
        end else if (addr == adr_cmd) begin
          rdata <= {29'h0, busy, cmd_reg};
        end else if (addr == adr_bus) begin
          rdata <= {22'h0, bus_reg};
        end else if (addr == adr_stat) begin
          rdata <= {25'h0, stable_reg};
        end
      end
    end
  end
endmodule : smd_ctrl

// ===== logic/smd_drive.sv
// drive end: selection, tag decode, address latches, write/read gating, fault
// assumes cable levels are asynchronous to clk
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
module smd_drive (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  smd_if.drive cab,
  input wire logic [smd_pkg::sel_w-1:0] my_sel,
  input wire logic [smd_pkg::cyl_w-1:0] cyl_max,
  input wire logic wprot_in,
  input wire logic wfault_in,
  input wire logic seek_done,
  input wire logic amark_found,
  output logic [smd_pkg::cyl_w-1:0] cyl_addr,
  output logic [smd_pkg::head_w-1:0] head_addr,
  output logic write_en,
  output logic write_mark,
  output logic read_en,
  output logic mark_search
);
  import smd_pkg::*;
  localparam int in_w = 1 + sel_w + 1 + tag_w + bus_w;
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [in_w-1:0] s1_reg, s2_reg, s3_reg;
  logic [in_w-1:0] stable_reg;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      stable_reg <= '0;
    end else if (ce) begin
      s1_reg <= {cab.sel_en, cab.sel_num, cab.if_en, cab.tag, cab.bus};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // per-bit agreement filter
      for (int i = 0; i < in_w; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          stable_reg[i] <= s3_reg[i];
        end
      end
    end
  end
  logic sel_en_s, if_en_s;
  logic [sel_w-1:0] sel_num_s;
  logic [tag_w-1:0] tag_s;
  logic [bus_w-1:0] bus_s;
  assign {sel_en_s, sel_num_s, if_en_s, tag_s, bus_s} = stable_reg;
  logic sel_en_d_reg;
  logic [tag_w-1:0] tag_d_reg;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_en_d_reg <= 1'b0;
      tag_d_reg <= '0;
    end else if (ce) begin
      sel_en_d_reg <= sel_en_s;
      tag_d_reg <= tag_s;
    end
  end
  // ----------------------------------------
  // selection
  // ----------------------------------------
  logic sel_reg;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_reg <= 1'b0;
    end else if (ce) begin
      if (!if_en_s || !sel_en_s) begin
        sel_reg <= 1'b0;
      end else if (!sel_en_d_reg && sel_num_s == my_sel) begin
        sel_reg <= 1'b1;
      end
      // once set, number changes are ignored
    end
  end
  logic active;
  assign active = sel_reg && if_en_s;
  logic [tag_w-1:0] tag_rise, tag_fall, tag_lvl;
  // a tag level or rise counts only when it stands alone
  assign tag_lvl = ($countones(tag_s) == 1 && active) ? tag_s : '0;
  assign tag_rise = tag_lvl & ~tag_d_reg;
  assign tag_fall = ~tag_s & tag_d_reg & {tag_w{active}};
  // ----------------------------------------
  // address latches and seek status
  // ----------------------------------------
  logic seek_err_reg, on_cyl_reg, fault_reg;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cyl_addr <= cyl_reset;
      head_addr <= head_reset;
    end else if (ce) begin
      if (tag_lvl[tag_cyl]) begin
        cyl_addr <= bus_s[cyl_w-1:0];
      end
      if (tag_lvl[tag_head]) begin
        head_addr <= bus_s[head_w-1:0];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seek_err_reg <= 1'b0;
      on_cyl_reg <= 1'b0;
    end else if (ce) begin
      if (tag_rise[tag_cyl] && bus_s[cyl_w-1:0] > cyl_max) begin
        seek_err_reg <= 1'b1;
      end else if (tag_lvl[tag_ctl] && bus_s[bit_rezero]) begin
        seek_err_reg <= 1'b0;
      end
      if (tag_fall[tag_cyl]) begin
        on_cyl_reg <= 1'b0;
      end else if (seek_done) begin
        on_cyl_reg <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // control bits and fault
  // ----------------------------------------
  logic ctl;
  assign ctl = tag_lvl[tag_ctl];
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fault_reg <= 1'b0;
    end else if (ce) begin
      // set wins over a simultaneous reset
      if (ctl && bus_s[bit_wgate] && (wprot_in || wfault_in)) begin
        fault_reg <= 1'b1;
      end else if (ctl && bus_s[bit_fault_reset]) begin
        fault_reg <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      write_en <= 1'b0;
      write_mark <= 1'b0;
      read_en <= 1'b0;
      mark_search <= 1'b0;
    end else if (ce) begin
      write_en <= ctl && bus_s[bit_wgate] && !bus_s[bit_am_en] && !fault_reg && !wprot_in;
      write_mark <= ctl && bus_s[bit_wgate] && bus_s[bit_am_en] && !fault_reg && !wprot_in;
      read_en <= ctl && bus_s[bit_rgate] && !bus_s[bit_am_en] && !fault_reg;
      mark_search <= ctl && bus_s[bit_rgate] && bus_s[bit_am_en] && !fault_reg;
    end
  end
  // ----------------------------------------
  // cable outputs
  // ----------------------------------------
  logic selected_reg, oe_n_reg;
  logic [st_w-1:0] st_reg;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      selected_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      st_reg <= '0;
    end else if (ce) begin
      selected_reg <= active;
      oe_n_reg <= !active;
      st_reg[st_fault] <= fault_reg;
      st_reg[st_seek_err] <= seek_err_reg;
      st_reg[st_on_cyl] <= on_cyl_reg; // fault leaves this alone
      st_reg[st_ready] <= !fault_reg;
      st_reg[st_wprot] <= wprot_in;
      st_reg[st_amark] <= mark_search && amark_found;
    end
  end
  assign cab.selected = selected_reg;
  assign cab.status_oe_n = oe_n_reg;
  assign cab.status_o = st_reg;
endmodule : smd_drive

// ===== shared/smd_if.sv
// control cable plus the read/write cable's SELECTED line
// drive-side status outputs are resolved from their enable here; selected is passed straight through
`timescale 1ns/1ns
interface smd_if;
  import smd_pkg::*;
  logic sel_en;
  logic [sel_w-1:0] sel_num;
  logic if_en;
  logic [tag_w-1:0] tag;
  logic [bus_w-1:0] bus;
  logic selected;
  logic [st_w-1:0] status_o;
  logic status_oe_n;
  logic [st_w-1:0] status;
  assign status = status_oe_n ? '0 : status_o;
  modport drive (input sel_en, sel_num, if_en, tag, bus, output selected, status_o, status_oe_n);
  modport ctrl (output sel_en, sel_num, if_en, tag, bus, input selected, status);
endinterface : smd_if

// ===== shared/smd_pkg.sv
// constants and types shared by the drive end and the control-unit end
// assumes one 250 MHz clock, synchronous active-high reset
// Function
// - controller drives twenty lines toward drive
// - select number is binary, weights 8..1
// - select on enable rise when number matches
// - SELECTED held until enable falls
// - selection survives select-number changes
// - control transmitters high-impedance unless selected
// - interface enable gates selection and operation
// - controller holds interface enable low at power
// - tags one at a time, only when selected
// - set cylinder takes bus 9..0
// - invalid cylinder raises seek error on rise
// - set cylinder fall clears on-cylinder, seek end
// - head set takes bus 6..0
// - control select makes bus control bits
// - bus 0 write gate writes data
// - write gate with mark enable records mark
// - write faults reported on fault line
// - only mark enable combines with write gate
// - bus 1 read gate reads or searches
// - status gated onto cable only when selected
// - fault inhibits read, write, clears ready
// - write gate while protected raises fault
package smd_pkg;
  localparam int sel_w = 4;
  localparam int bus_w = 10;
  localparam int cyl_w = 10;
  localparam int head_w = 7;
  localparam int tag_w = 4;
  // tag line positions
  localparam int tag_cyl = 0;
  localparam int tag_head = 1;
  localparam int tag_ctl = 2;
  localparam int tag_spare = 3;
  // control bit positions on the bus
  localparam int bit_wgate = 0;
  localparam int bit_rgate = 1;
  localparam int bit_fault_reset = 4;
  localparam int bit_am_en = 5;
  localparam int bit_rezero = 6;
  // status word layout
  localparam int st_w = 6;
  localparam int st_fault = 0;
  localparam int st_seek_err = 1;
  localparam int st_on_cyl = 2;
  localparam int st_ready = 3;
  localparam int st_wprot = 4;
  localparam int st_amark = 5;
  localparam logic [cyl_w-1:0] cyl_max_default = 10'h32a;
  localparam logic [cyl_w-1:0] cyl_reset = 10'h000;
  localparam logic [head_w-1:0] head_reset = 7'h00;
  // controller register map
  localparam logic [3:0] adr_sel = 4'h0;
  localparam logic [3:0] adr_cmd = 4'h1;
  localparam logic [3:0] adr_bus = 4'h2;
  localparam logic [3:0] adr_stat = 4'h3;
  localparam logic [31:0] word_zero = 32'h0000_0000;
  // levels held per tag step, in clock cycles
  localparam int tag_setup_cyc = 8;
  localparam int tag_hold_cyc = 8;
  localparam int cnt_w = 4;
  typedef enum logic [1:0] {cmd_none, cmd_cyl, cmd_head, cmd_ctl} cmd_t;
endpackage : smd_pkg

// ===== verification/smd_checker.sv
// cable-level assertions between the control-unit end and the drive end
// assumes one clock and the interface signals wired in by name
`timescale 1ns/1ns
module smd_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sel_en,
  input wire logic [smd_pkg::sel_w-1:0] sel_num,
  input wire logic if_en,
  input wire logic [smd_pkg::tag_w-1:0] tag,
  input wire logic [smd_pkg::bus_w-1:0] bus,
  input wire logic selected,
  input wire logic [smd_pkg::st_w-1:0] status_o,
  input wire logic status_oe_n
);
  import smd_pkg::*;
  // --------------------------------
  // properties
  // --------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_tags_one_hot: assert property ($onehot0(tag)) else $error("two tags at once");
  // three idle cycles are margin only; the enable register switches in the same cycle as selected
  a_quiet_unselected: assert property (!selected [*3] |-> status_oe_n) else $error("status driven unselected");
  a_select_cause: assert property ($rose(selected) |-> $past(sel_en, 4) && $past(if_en, 4))
    else $error("selected without enables");
  a_drop_on_enable: assert property ($fell(sel_en) |-> ##[1:8] !selected) else $error("selected stuck");
  a_drop_on_ifen: assert property ($fell(if_en) |-> ##[1:8] !selected) else $error("not disabled");
  a_selection_held: assert property ((sel_en && if_en) [*8] ##0 selected |=> selected)
    else $error("selection lost");
  a_bus_steady_tag: assert property ((|tag[1:0]) && $past(|tag[1:0]) |-> $stable(bus))
    else $error("bus moved under tag");
  a_fault_not_ready: assert property (status_o[st_fault] && $past(status_o[st_fault]) |-> !status_o[st_ready])
    else $error("ready during fault");
endmodule : smd_checker

// ===== verification/tb_disk_drive_control_cable_port.sv
// register-port tests of the control-unit end driving the drive end
// assumes the two ends meet in smd_if; cable latency is a few cycles
`timescale 1ns/1ns
module tb_disk_drive_control_cable_port;
  import smd_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0, rd = 1'b0;
  logic [31:0] rdata, s;
  logic [sel_w-1:0] my_sel = 4'h5;
  logic [cyl_w-1:0] cyl_max = cyl_max_default;
  logic wprot_in = 1'b0, wfault_in = 1'b0, seek_done = 1'b1, amark_found = 1'b1;
  logic [cyl_w-1:0] cyl_addr;
  logic [head_w-1:0] head_addr;
  logic write_en, write_mark, read_en, mark_search;
  logic [9:0] ctl_bus [4] = '{10'h001, 10'h021, 10'h002, 10'h022};
  logic [3:0] ctl_mask [4] = '{4'hf, 4'h7, 4'hf, 4'hd};
  logic [3:0] ctl_exp [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
  int n_mismatch = 0, n_checks = 0, cycles = 0;
  always #2 clk = ~clk;
  // --------------------------------
  // ends, cable and checker
  // --------------------------------
  smd_if cab_if();
  smd_ctrl smd_ctrl_inst (.clk(clk), .sys_rst(sys_rst), .ce(ce), .cab(cab_if), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));
  smd_drive smd_drive_inst (.clk(clk), .sys_rst(sys_rst), .ce(ce), .cab(cab_if), .my_sel(my_sel),
    .cyl_max(cyl_max), .wprot_in(wprot_in), .wfault_in(wfault_in), .seek_done(seek_done),
    .amark_found(amark_found), .cyl_addr(cyl_addr), .head_addr(head_addr), .write_en(write_en),
    .write_mark(write_mark), .read_en(read_en), .mark_search(mark_search));
  smd_checker smd_checker_inst (.clk(clk), .sys_rst(sys_rst), .sel_en(cab_if.sel_en), .sel_num(cab_if.sel_num),
    .if_en(cab_if.if_en), .tag(cab_if.tag), .bus(cab_if.bus), .selected(cab_if.selected),
    .status_o(cab_if.status_o), .status_oe_n(cab_if.status_oe_n));
  // --------------------------------
  // tasks
  // --------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_stat();
    @(posedge clk);
    addr <= adr_stat;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 s = rdata;
  endtask : rd_stat
  // fixed waits cover the three-flop cable sampling plus the tag step
  task automatic sel(input logic [3:0] num, input logic en, input logic ife);
    wr_reg(adr_sel, {26'h0, ife, en, num});
    repeat (20) @(posedge clk);
    rd_stat();
  endtask : sel
  task automatic cmd(input cmd_t c, input logic [9:0] b);
    wr_reg(adr_bus, {22'h0, b});
    wr_reg(adr_cmd, 32'(c));
    repeat (30) @(posedge clk);
    rd_stat();
  endtask : cmd
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // --------------------------------
  // sequence
  // --------------------------------
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd_stat();
    check("idle status", s, 32'h0);
    sel(4'h3, 1'b1, 1'b1);
    check("other number", 32'(s[6]), 32'h0);
    sel(4'h5, 1'b0, 1'b0);
    sel(4'h5, 1'b1, 1'b0);
    check("interface off", 32'(s[6]), 32'h0);
    sel(4'h5, 1'b0, 1'b1);
    sel(4'h5, 1'b1, 1'b1);
    check("selected ready", 32'({s[6], s[st_ready]}), 32'h3);
    my_sel <= 4'h9;
    sel(4'h3, 1'b1, 1'b1);
    check("selection kept", 32'(s[6]), 32'h1);
    my_sel <= 4'h5;
    seek_done <= 1'b0;
    cmd(cmd_cyl, 10'h155);
    check("cylinder", 32'(cyl_addr), 32'h155);
    check("seek flags", 32'({s[st_seek_err], s[st_on_cyl]}), 32'h0);
    seek_done <= 1'b1;
    cmd(cmd_head, 10'h3a5);
    check("head", 32'({cyl_addr, head_addr}), {15'h0, 10'h155, 7'h25});
    cmd(cmd_cyl, 10'h3ff);
    check("seek error", 32'(s[st_seek_err]), 32'h1);
    cmd(cmd_ctl, 10'h040);
    check("seek error clear", 32'(s[st_seek_err]), 32'h0);
    for (int i = 0; i < 4; i++) begin
      cmd(cmd_ctl, ctl_bus[i]);
      check("gates", 32'({write_en, write_mark, read_en, mark_search} & ctl_mask[i]), 32'(ctl_exp[i]));
      check("mark seen", 32'(s[st_amark]), 32'(i == 3));
    end
    // fault set from either source, then cleared by fault reset after the source is gone
    for (int i = 0; i < 2; i++) begin
      wprot_in <= (i == 0);
      wfault_in <= (i == 1);
      cmd(cmd_ctl, 10'h001);
      check("fault", 32'({s[st_fault], s[st_ready], write_en}), 32'h4);
      check("protect status", 32'(s[st_wprot]), 32'(i == 0));
      wprot_in <= 1'b0;
      wfault_in <= 1'b0;
      cmd(cmd_ctl, 10'h010);
      check("fault clear", 32'({s[st_fault], s[st_ready]}), 32'h1);
    end
    sel(4'h3, 1'b0, 1'b1);
    check("deselected", s, 32'h0);
    sel(4'h5, 1'b1, 1'b1);
    check("reselected", 32'(s[6]), 32'h1);
    sel(4'h5, 1'b1, 1'b0);
    check("interface dropped", s, 32'h0);
    cmd(cmd_head, 10'h011);
    check("tag unselected", 32'(head_addr), 32'h25);
    give_verdict();
  end
endmodule : tb_disk_drive_control_cable_port
